// >>> core/adc_readout_pkg.sv
/*
  Shared constants and carrier types for the converter result readout.
  Assumes a single 250 MHz system clock and a slow external serial link.
*/
package adc_readout_pkg;
  localparam int RESULT_W = 16;
  localparam int LEAD_ZEROS = 8;
  localparam int FRAME_BITS = 24;
  localparam int CONV_START_EDGE = 6;
  localparam int FIFO_DEPTH = 16;
  localparam logic [4:0] BIT_CNT_RESET = 5'h00;
  localparam logic [4:0] LAST_EDGE = 5'h18;

  typedef enum logic [2:0] {
    ST_SHUTDOWN = 3'b001,
    ST_ACQUIRE = 3'b010,
    ST_CONVERT = 3'b100
  } conv_state_e;

  typedef struct packed {
    logic sclk;
    logic cs_n;
  } link_in_s;

  typedef struct packed {
    logic dout_o;
    logic dout_oe;
  } link_out_s;
endpackage

// >>> core/adc_result_fifo.sv
/*
  Holds no logic: the result FIFO module sits in the readout core file beside its user.
  Assumes that core file is part of every build that uses the readout.
*/

// >>> core/adc_result_spi_readout.sv
/*
  Serial readout of a 16-bit converter result: leading zero byte, then result MSB first.
  Also holds the result FIFO that buffers converter words ahead of the shifter.
  Assumes the master drives chip select and an idle-low serial clock; both pins are
  sampled by clk, which must run several times faster than the serial clock.
*/
// Overview of operation
// R1 - Full result needs three back-to-back byte transfers with chip select low.
// R2 - Data output changes only on serial clock falling edges.
// R3 - Master captures each data bit on the serial clock rising edge.
// R4 - First byte transfer carries only zero bits.
// R5 - Second byte carries result MSB down to bit 8.
// R6 - Third byte carries result bits 7 down to 0.
// R7 - Host acts as link master and alone makes the serial clock.
// R8 - Master moves 8 bits per transfer, full duplex; received bytes matter.
// R9 - Master sets its port enable bit to 1.
// R10 - Master clears clock polarity bit, serial clock idles low.
// R11 - Master mode field is 0001, oscillator divided by 16.
// R12 - Master clears sample phase bit, samples mid data period.
// R13 - Master sets clock edge select bit to 1.
// R14 - Chip select fall starts acquisition, drives output low; convert after sixth clock.
// R15 - Extra clocks after last bit give zeros, conversion state unchanged.
// R16 - Chip select rise after last bit clears registers, enters shutdown.
// R17 - Chip select rise mid-conversion aborts it and enters shutdown.
// R18 - Master keeps chip select low across all three bytes.
`timescale 1ns/10ps
module adc_result_spi_readout
  import adc_readout_pkg::*;
#(
  parameter int WIDTH = adc_readout_pkg::RESULT_W,
  parameter int DEPTH = adc_readout_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial link pins
  input wire adc_readout_pkg::link_in_s link_in,
  output adc_readout_pkg::link_out_s link_out,
  // Sample source
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [WIDTH-1:0] sample_data,
  // Status
  output logic converting,
  output logic shutdown
);
  import adc_readout_pkg::*;

  logic [1:0] sclk_sync_reg;
  logic [1:0] cs_sync_reg;
  logic sclk_prev_reg;
  logic cs_prev_reg;
  logic [4:0] edge_cnt_reg;
  logic [4:0] edge_cnt_next;
  logic [WIDTH-1:0] shift_reg;
  logic [WIDTH-1:0] shift_next;
  logic dout_reg;
  logic dout_next;
  logic oe_reg;
  conv_state_e state_reg;
  conv_state_e state_next;
  logic fifo_valid;
  logic [WIDTH-1:0] fifo_data;

  // Two-stage synchronisers; only the second stage is read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_sync_reg <= 2'h0;
      cs_sync_reg <= 2'h3;
      sclk_prev_reg <= 1'b0;
      cs_prev_reg <= 1'b1;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], link_in.sclk};
      cs_sync_reg <= {cs_sync_reg[0], link_in.cs_n};
      sclk_prev_reg <= sclk_sync_reg[1];
      cs_prev_reg <= cs_sync_reg[1];
    end
  end

  wire sclk_s = sclk_sync_reg[1];
  wire cs_n_s = cs_sync_reg[1];
  wire cs_fall = cs_prev_reg && !cs_n_s;
  wire cs_rise = !cs_prev_reg && cs_n_s;
  wire sclk_fall = sclk_prev_reg && !sclk_s && !cs_n_s;
  wire sclk_rise = !sclk_prev_reg && sclk_s && !cs_n_s;
  wire frame_done = (edge_cnt_reg >= LAST_EDGE); // R1
  wire in_lead = (edge_cnt_reg < 5'(LEAD_ZEROS - 1));
  wire conv_start = sclk_rise && (edge_cnt_reg == 5'(CONV_START_EDGE - 1));
  wire take_sample = conv_start && fifo_valid;

  adc_result_fifo #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_data),
    .out_valid(fifo_valid),
    .out_ready(take_sample),
    .out_data(fifo_data)
  );

  // Conversion state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_SHUTDOWN: begin
        if (cs_fall) begin
          state_next = ST_ACQUIRE; // R14
        end
      end
      ST_ACQUIRE: begin
        if (cs_rise) begin
          state_next = ST_SHUTDOWN; // R17
        end else if (conv_start) begin
          state_next = ST_CONVERT; // R14
        end
      end
      ST_CONVERT: begin
        if (cs_rise) begin
          state_next = ST_SHUTDOWN; // R16 R17
        end
      end
      default: state_next = ST_SHUTDOWN;
    endcase
  end

  // Falling-edge counter and output shifter
  always_comb begin
    edge_cnt_next = edge_cnt_reg;
    shift_next = shift_reg;
    dout_next = dout_reg;
    if (cs_rise || cs_fall) begin
      edge_cnt_next = BIT_CNT_RESET; // R16
      shift_next = '0;
      dout_next = 1'b0; // R14
    end else begin
      if (take_sample) begin
        shift_next = fifo_data;
      end
      if (sclk_fall) begin // R2
        if (frame_done) begin
          dout_next = 1'b0; // R15
        end else begin
          edge_cnt_next = edge_cnt_reg + 5'h01;
          if (in_lead) begin
            dout_next = 1'b0; // R4
          end else if (edge_cnt_reg == LAST_EDGE - 5'h01) begin
            dout_next = 1'b0; // R15
          end else begin
            dout_next = shift_reg[WIDTH-1]; // R5 R6
            shift_next = {shift_reg[WIDTH-2:0], 1'b0};
          end
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg <= ST_SHUTDOWN;
      edge_cnt_reg <= BIT_CNT_RESET;
      shift_reg <= '0;
      dout_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      edge_cnt_reg <= edge_cnt_next;
      shift_reg <= shift_next;
      dout_reg <= dout_next;
      oe_reg <= !cs_n_s; // R14
    end
  end

  assign link_out.dout_o = dout_reg;
  assign link_out.dout_oe = oe_reg;
  assign converting = (state_reg == ST_CONVERT);
  assign shutdown = (state_reg == ST_SHUTDOWN);
endmodule

// Result FIFO, valid and ready on both sides; write and read may share a cycle
module adc_result_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire do_wr = in_valid && in_ready;
  wire do_rd = out_valid && out_ready;

  assign in_ready = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];

  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule

// >>> sim/adc_result_spi_readout_sva.sv
/* Pin checks for the readout. Bound to its top; sees only its ports. */
`timescale 1ns/10ps
module adc_result_spi_readout_sva
  import adc_readout_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire adc_readout_pkg::link_in_s link_in,
  input wire adc_readout_pkg::link_out_s link_out,
  input wire logic sample_ready,
  input wire logic converting,
  input wire logic shutdown
);
  logic sclk_d;
  logic [4:0] fcnt;
  logic [2:0] age;
  wire s_fall = !link_in.sclk && sclk_d;
  wire live = link_out.dout_oe && !link_in.cs_n;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Falls seen in the frame, and cycles since the last one
  always_ff @(posedge clk) begin
    sclk_d <= link_in.sclk;
    fcnt <= (sys_rst || link_in.cs_n) ? 5'h00 : fcnt + 5'(s_fall);
    age <= sys_rst ? 3'h7 : s_fall ? 3'h0 : age + 3'(age != 3'h7);
  end
  AST_DOUT_FALL: assert property ($changed(link_out.dout_o) && link_out.dout_oe &&
    $past(link_out.dout_oe) |-> age != 3'h7) else $error("dout moved off a fall");
  AST_CS_FALL: assert property ($fell(link_in.cs_n) |-> ##[2:5]
    link_out.dout_oe && !link_out.dout_o) else $error("no low drive after select");
  AST_CS_RISE: assert property ($rose(link_in.cs_n) |-> ##[2:6]
    shutdown && !converting && !link_out.dout_oe) else $error("no shutdown");
  AST_IDLE: assert property (link_in.cs_n [*6] |-> shutdown && !link_out.dout_oe)
    else $error("active while deselected");
  AST_CONV_SIXTH: assert property ($rose(converting) |-> fcnt == 5'h05)
    else $error("conversion not after sixth clock");
  AST_LEAD: assert property (live && fcnt <= 5'h07 |-> !link_out.dout_o)
    else $error("leading bit not zero");
  AST_TRAIL: assert property (live && fcnt >= 5'h18 && age >= 3'h2 |-> !link_out.dout_o)
    else $error("trailing bit not zero");
  AST_EXCL: assert property (shutdown |-> !converting && !link_out.dout_oe)
    else $error("converting or driving in shutdown");
  cover property ($rose(converting));
  cover property (fcnt == 5'h1c);
  cover property (!sample_ready);
endmodule
bind adc_result_spi_readout adc_result_spi_readout_sva chk (.clk(clk), .sys_rst(sys_rst),
  .link_in(link_in), .link_out(link_out), .sample_ready(sample_ready),
  .converting(converting), .shutdown(shutdown));

// >>> sim/spi_master_model.sv
/* Serial master: drives select and clock, samples data out. Called by the bench. */
`timescale 1ns/10ps
module spi_master_model
  import adc_readout_pkg::*;
(
  output adc_readout_pkg::link_in_s link,
  input wire adc_readout_pkg::link_out_s pins
);
  localparam logic [7:0] host_port_control_register = 8'h21;
  localparam logic [7:0] host_port_status_register = 8'h40;
  localparam int HALF = 16;
  logic [31:0] rx;
  initial begin
    link = '{sclk: host_port_control_register[4], cs_n: 1'b1};
    rx = 32'h0;
  end
  task automatic frame(input int n);
    int k;
    rx = 32'h0;
    link.cs_n = 1'b0;
    #40;
    for (k = 0; k < n; k++) begin
      #HALF link.sclk = host_port_control_register[5];
      // Undriven line reads as the inverse of its last value
      rx = {rx[30:0], pins.dout_oe ? pins.dout_o : ~pins.dout_o};
      #HALF link.sclk = host_port_control_register[4];
    end
    #40 link.cs_n = 1'b1;
    #60;
  endtask
endmodule

// >>> sim/adc_result_spi_readout_bench.sv
/* Readout bench: fill FIFO, drain by frames, abort. Needs the master model. */
`timescale 1ns/10ps
module adc_result_spi_readout_bench;
  import adc_readout_pkg::*;
  logic clk, sys_rst, sample_valid, sample_ready, converting, shutdown;
  logic [RESULT_W-1:0] sample_data;
  link_in_s link_in;
  link_out_s link_out;
  int failures, checked, i;
  adc_result_spi_readout DUT (.clk(clk), .sys_rst(sys_rst), .link_in(link_in),
    .link_out(link_out), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_data(sample_data), .converting(converting), .shutdown(shutdown));
  spi_master_model m (.link(link_in), .pins(link_out));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [15:0] word(input int k);
    return 16'h8c31 ^ (16'(k) * 16'h1357);
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    failures++;
    report_and_stop;
  end
  initial begin
    sys_rst = 1'b1;
    sample_valid = 1'b0;
    sample_data = 16'h0000;
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge clk);
    sample_valid = 1'b1;
    for (i = 0; i < 16; i++) begin
      sample_data = word(i);
      @(negedge clk);
    end
    sample_valid = 1'b0;
    check("ready", 32'h0, 32'(sample_ready));
    $display("fill done");
    for (i = 0; i < 16; i++) begin
      m.frame(i == 15 ? 28 : 24);
      check("rx", {16'h0000, word(i)} << (i == 15 ? 4 : 0), m.rx);
      check("shutdown", 32'h1, 32'(shutdown));
    end
    $display("drain done");
    fork
      m.frame(10);
      begin
        // Mid-frame, past the sixth rising edge, before select rises
        #300;
        check("converting", 32'h1, 32'(converting));
      end
    join
    check("abort", 32'h1, 32'(shutdown & ~converting));
    m.frame(24);
    check("empty", 32'h0, m.rx);
    $display("abort done");
    report_and_stop;
  end
endmodule
